// [core/lcc_chan_if.sv]
// Carrier between the startup sequencer and the channel offset unit.
// Assumes both ends run on the same clock.
`default_nettype none

interface lcc_chan_if;
	import lcc_pkg::*;
	logic                   in_valid;
	logic [7:0]             in_value;
	lcc_ofs_mode_type       mode;
	logic [7:0]             hyst;
	logic [1:0][8:0]        offset;
	logic [1:0][8:0]        pct;
	logic [1:0][7:0]        sync;
	logic                   out_valid;
	logic [2:0][7:0]        out_value;

	modport ctrl (output in_valid, in_value, mode, hyst, offset, pct, sync,
		input out_valid, out_value);
	modport drv (input in_valid, in_value, mode, hyst, offset, pct, sync,
		output out_valid, out_value);
endinterface : lcc_chan_if

`default_nettype wire

// [core/lcc_ctrl.sv]
// Constant-light control: setpoint selection, startup control and channel outputs.
// Assumes all inputs come from logic on clk; telegram outputs are one-cycle strobes.
`default_nettype none
`include "lcc_regs.svh"

module lcc_ctrl #(
	parameter int MS_CYCLES = `LCC_MS_NS / `LCC_CLK_NS
) (
	// Clock and reset.
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	// Setpoint sources.
	input  wire logic [15:0]              cfg_setpoint,
	input  wire logic                     cfg_overwrite,
	input  wire logic                     cfg_download,
	input  wire logic                     ext_sp_valid,
	input  wire logic [15:0]              ext_sp_value,
	input  wire logic                     teach,
	input  wire logic                     sp_reset,
	output logic [15:0]                   setpoint_active,
	// Brightness measurement.
	input  wire logic [15:0]              measured_lux,
	// Channel configuration.
	input  wire logic [1:0]               num_channels,
	input  wire lcc_pkg::lcc_ofs_mode_type ofs_mode,
	input  wire logic [7:0]               ofs_hyst,
	input  wire logic [8:0]               ofs_ch2,
	input  wire logic [8:0]               ofs_ch3,
	input  wire logic [8:0]               pct_ch2,
	input  wire logic [8:0]               pct_ch3,
	input  wire logic [7:0]               sync_ch2,
	input  wire logic [7:0]               sync_ch3,
	// Startup configuration.
	input  wire lcc_pkg::lcc_su_mode_type su_mode,
	input  wire logic [2:0]               dim_step,
	input  wire logic [15:0]              repeat_ms,
	input  wire logic [7:0]               fixed_value,
	input  wire logic [15:0]              adapt_range,
	input  wire logic                     startup_start,
	output logic                          startup_done,
	// Channel 1 value from the main control phase.
	input  wire logic                     main_valid,
	input  wire logic [7:0]               main_value,
	// Telegrams to the actuators.
	output logic                          sw_valid,
	output logic                          sw_value,
	output logic                          dim_valid,
	output logic [3:0]                    dim_cmd,
	output logic [2:0]                    ch_valid,
	output logic [7:0]                    ch1_value,
	output logic [7:0]                    ch2_value,
	output logic [7:0]                    ch3_value
);
	import lcc_pkg::*;

	localparam logic [17:0] MS_COUNT = 18'(MS_CYCLES - 1);

	// ****************************************
	// Setpoint selection
	// ****************************************
	logic        learned_reg;
	logic [15:0] sp_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			learned_reg <= 1'b0;
			sp_reg      <= `LCC_SP_RST;
		end else if (ext_sp_valid) begin
			learned_reg <= 1'b1;
			sp_reg      <= ext_sp_value;
		end else if (teach) begin
			learned_reg <= 1'b1;
			sp_reg      <= measured_lux;
		end else if (sp_reset || (cfg_download && cfg_overwrite)) begin
			learned_reg <= 1'b0;
		end
	end

	// Without overwrite a download leaves the learned value untouched.
	assign setpoint_active = learned_reg ? sp_reg : cfg_setpoint;

	// ****************************************
	// Startup sequencer
	// ****************************************
	lcc_state_type state_reg;
	logic          single;
	logic          below;
	logic [17:0]   ms_cnt_reg;
	logic          ms_tick;
	logic [15:0]   elapsed_reg;
	logic          sw_valid_reg;
	logic          dim_valid_reg;
	logic [3:0]    dim_cmd_reg;
	logic          done_reg;
	logic          su_val_reg;
	logic [7:0]    su_data_reg;
	logic [7:0]    adapt_value;
	logic [23:0]   adapt_q;
	logic          rel_ok;

	assign single  = (num_channels <= 2'h1);
	assign below   = measured_lux < setpoint_active;
	assign ms_tick = (ms_cnt_reg == MS_COUNT);
	assign rel_ok  = single && (su_mode == LCC_SU_SWITCH || su_mode == LCC_SU_RELDIM);

	// Adaptive value: shortfall scaled over the brightness range, at least 1.
	always_comb begin
		adapt_q = 24'h000000;
		if (adapt_range != 16'h0000) begin
			adapt_q = 24'((24'(setpoint_active - measured_lux) * 24'h0000FF)
				/ 24'(adapt_range));
		end
		if (adapt_range == 16'h0000 || adapt_q > 24'h0000FF) begin
			adapt_value = `LCC_VAL_MAX;
		end else if (adapt_q == 24'h000000) begin
			adapt_value = 8'h01;
		end else begin
			adapt_value = adapt_q[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || state_reg != LCC_ST_DIM || ms_tick) begin
			ms_cnt_reg <= 18'h00000;
		end else begin
			ms_cnt_reg <= ms_cnt_reg + 18'h00001;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg     <= LCC_ST_IDLE;
			elapsed_reg   <= 16'h0000;
			sw_valid_reg  <= 1'b0;
			dim_valid_reg <= 1'b0;
			dim_cmd_reg   <= `LCC_DIM_STOP;
			done_reg      <= 1'b0;
			su_val_reg    <= 1'b0;
			su_data_reg   <= `LCC_VAL_RST;
		end else begin
			sw_valid_reg  <= 1'b0;
			dim_valid_reg <= 1'b0;
			done_reg      <= 1'b0;
			su_val_reg    <= 1'b0;
			unique case (state_reg)
				LCC_ST_IDLE: begin
					if (startup_start) begin
						state_reg <= LCC_ST_CHECK;
					end
				end
				LCC_ST_CHECK: begin
					state_reg <= LCC_ST_IDLE;
					if (!below) begin
						done_reg <= 1'b1;
					end else if (rel_ok && su_mode == LCC_SU_SWITCH) begin
						sw_valid_reg <= 1'b1;
						done_reg     <= 1'b1;
					end else if (rel_ok) begin
						dim_valid_reg <= 1'b1;
						dim_cmd_reg   <= {`LCC_DIM_UP_BIT, dim_step};
						elapsed_reg   <= 16'h0000;
						state_reg     <= LCC_ST_DIM;
					end else begin
						// Several channels fall back to an absolute value.
						su_val_reg  <= 1'b1;
						su_data_reg <= (su_mode == LCC_SU_ADAPT) ? adapt_value : fixed_value;
						done_reg    <= 1'b1;
					end
				end
				LCC_ST_DIM: begin
					if (!below) begin
						dim_valid_reg <= 1'b1;
						dim_cmd_reg   <= `LCC_DIM_STOP;
						done_reg      <= 1'b1;
						state_reg     <= LCC_ST_IDLE;
					end else if (ms_tick) begin
						if (elapsed_reg + 16'h0001 >= repeat_ms) begin
							dim_valid_reg <= 1'b1;
							dim_cmd_reg   <= {`LCC_DIM_UP_BIT, dim_step};
							elapsed_reg   <= 16'h0000;
						end else begin
							elapsed_reg <= elapsed_reg + 16'h0001;
						end
					end
				end
				default: begin
					state_reg <= LCC_ST_IDLE;
				end
			endcase
		end
	end

	assign sw_valid     = sw_valid_reg;
	assign sw_value     = `LCC_SWITCH_ON;
	assign dim_valid    = dim_valid_reg;
	assign dim_cmd      = dim_cmd_reg;
	assign startup_done = done_reg;

	// ****************************************
	// Channel outputs
	// ****************************************
	lcc_chan_if chan ();

	assign chan.in_valid  = su_val_reg || main_valid;
	assign chan.in_value  = su_val_reg ? su_data_reg : main_value;
	assign chan.mode      = ofs_mode;
	assign chan.hyst      = ofs_hyst;
	assign chan.offset    = {ofs_ch3, ofs_ch2};
	assign chan.pct       = {pct_ch3, pct_ch2};
	assign chan.sync      = {sync_ch3, sync_ch2};

	lcc_derive u_derive (
		.clk   (clk),
		.rst_n (rst_n),
		.ch    (chan.drv)
	);

	// Channels beyond the configured count stay silent.
	assign ch_valid[0] = chan.out_valid;
	assign ch_valid[1] = chan.out_valid && (num_channels >= 2'h2);
	assign ch_valid[2] = chan.out_valid && (num_channels == 2'h3);
	assign ch1_value   = chan.out_value[0];
	assign ch2_value   = chan.out_value[1];
	assign ch3_value   = chan.out_value[2];

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_sp_overwrite: assert property (cfg_download && cfg_overwrite && !ext_sp_valid && !teach
		|=> setpoint_active == cfg_setpoint)
		else $error("download with overwrite kept old setpoint");
	a_sp_keep: assert property (cfg_download && !cfg_overwrite && learned_reg && !ext_sp_valid
		&& !teach && !sp_reset |=> setpoint_active == $past(setpoint_active))
		else $error("download without overwrite changed setpoint");
	a_sp_learn_cause: assert property ($rose(learned_reg) |-> $past(ext_sp_valid || teach))
		else $error("configured setpoint left without a presetting");
	a_bright_ok: assert property (state_reg == LCC_ST_CHECK && !below
		|=> startup_done && !sw_valid && !dim_valid && !su_val_reg)
		else $error("startup acted although brightness sufficed");
	a_switch_on: assert property (state_reg == LCC_ST_CHECK && below && single
		&& su_mode == LCC_SU_SWITCH |=> sw_valid && sw_value ##1 !sw_valid)
		else $error("switching startup did not send on telegram");
	a_dim_stop: assert property (state_reg == LCC_ST_DIM && !below
		|=> dim_valid && dim_cmd == `LCC_DIM_STOP && state_reg == LCC_ST_IDLE)
		else $error("relative dimming not stopped at setpoint");
	a_single_only: assert property (state_reg == LCC_ST_CHECK && !single
		|=> !sw_valid && !dim_valid)
		else $error("switch or dim telegram with several channels");
	a_fixed_value: assert property (state_reg == LCC_ST_CHECK && below && !rel_ok
		&& su_mode == LCC_SU_VALUE |=> ##1 ch_valid[0] && ch1_value == $past(fixed_value, 2))
		else $error("fixed startup value not sent");

	c_bright_ok: cover property (state_reg == LCC_ST_CHECK && !below);
	c_dim_cycle: cover property (dim_valid && dim_cmd != `LCC_DIM_STOP ##[1:1000] dim_valid
		&& dim_cmd == `LCC_DIM_STOP);
	c_three_ch: cover property (ch_valid == 3'h7);

endmodule : lcc_ctrl

`default_nettype wire

// [core/lcc_derive.sv]
// Offset unit: derives channel 2 and 3 dimming values from the channel 1 value.
// Assumes a one-cycle value strobe on the carrier; results appear one cycle later.
`default_nettype none
`include "lcc_regs.svh"

module lcc_derive (
	// Clock and reset.
	input  wire logic  clk,
	input  wire logic  rst_n,
	// Carrier to the sequencer.
	lcc_chan_if.drv    ch
);
	import lcc_pkg::*;

	logic [7:0] c1;
	logic       valid_reg;
	logic [7:0] ch1_reg;

	assign c1 = ch.in_value;
	assign ch.out_valid = valid_reg;
	assign ch.out_value[0] = ch1_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			valid_reg <= 1'b0;
			ch1_reg   <= `LCC_VAL_RST;
		end else begin
			valid_reg <= ch.in_valid;
			if (ch.in_valid) begin
				ch1_reg <= c1;
			end
		end
	end

	// ****************************************
	// Per-channel derivation
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_ch
			logic signed [17:0] off;
			logic signed [17:0] raw;
			logic        [16:0] mag;
			logic               neg;
			logic               on_now;
			logic               on_reg;
			logic        [7:0]  val_reg;
			logic        [7:0]  val_next;

			assign off = 18'(signed'(ch.offset[gi]));
			assign neg = (ch.mode != LCC_OFS_INC) && ch.offset[gi][8];

			always_comb begin
				mag = 17'h00000;
				raw = 18'sh00000;
				unique case (ch.mode)
					LCC_OFS_FIXED: begin
						raw = 18'(signed'({10'h000, c1})) + off;
					end
					LCC_OFS_INC: begin
						mag = 17'((17'(c1) * 17'(ch.pct[gi])) / `LCC_PCT_FULL);
						raw = 18'(signed'({1'b0, mag}));
					end
					default: begin
						// Offset shrinks linearly from full at 1 to zero at sync.
						if (c1 < ch.sync[gi] && ch.sync[gi] > 8'h01) begin
							mag = 17'((17'(neg ? 9'(-ch.offset[gi]) : ch.offset[gi])
								* 17'(ch.sync[gi] - c1)) / 17'(ch.sync[gi] - 8'h01));
						end
						raw = 18'(signed'({10'h000, c1}))
							+ (neg ? -18'(signed'({1'b0, mag})) : 18'(signed'({1'b0, mag})));
					end
				endcase
				// Hysteresis on negative offsets: on above hyst, off at or below zero.
				if (raw > 18'(signed'({10'h000, ch.hyst}))) begin
					on_now = 1'b1;
				end else if (raw <= 18'sh00000) begin
					on_now = 1'b0;
				end else begin
					on_now = on_reg;
				end
				if (c1 == 8'h00 || (neg && !on_now) || raw <= 18'sh00000) begin
					val_next = 8'h00;
				end else if (raw > 18'sh000FF) begin
					val_next = `LCC_VAL_MAX;
				end else begin
					val_next = raw[7:0];
				end
			end

			always_ff @(posedge clk) begin
				if (!rst_n) begin
					on_reg  <= 1'b0;
					val_reg <= `LCC_VAL_RST;
				end else if (ch.in_valid) begin
					on_reg  <= on_now;
					val_reg <= val_next;
				end
			end
			assign ch.out_value[gi + 1] = val_reg;
		end
	endgenerate

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_zero_follow: assert property (ch.in_valid && c1 == 8'h00 && ch.mode != LCC_OFS_INC
		|=> ch.out_value[1] == 8'h00 && ch.out_value[2] == 8'h00)
		else $error("derived channel not off with channel 1 off");
	a_inc_lower: assert property (ch.in_valid && ch.mode == LCC_OFS_INC && c1 != 8'h00
		&& ch.pct[0] < 9'h064 |=> ch.out_value[1] < ch.out_value[0])
		else $error("percentage below full did not lower channel 2");
	a_dec_sync: assert property (ch.in_valid && ch.mode == LCC_OFS_DEC
		&& c1 >= ch.sync[0] |=> ch.out_value[1] == ch.out_value[0])
		else $error("channel 2 not synchronised beyond sync point");

endmodule : lcc_derive

`default_nettype wire

// [core/lcc_pkg.sv]
// Types shared by the constant-light control modules.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package lcc_pkg;

	// Offset method for channels 2 and 3.
	typedef enum logic [1:0] {LCC_OFS_FIXED, LCC_OFS_INC, LCC_OFS_DEC} lcc_ofs_mode_type;

	// Startup control behaviour.
	typedef enum logic [1:0] {LCC_SU_SWITCH, LCC_SU_RELDIM, LCC_SU_VALUE, LCC_SU_ADAPT}
		lcc_su_mode_type;

	// Startup sequencer states.
	typedef enum logic [1:0] {LCC_ST_IDLE, LCC_ST_CHECK, LCC_ST_DIM} lcc_state_type;

endpackage : lcc_pkg

`default_nettype wire

// [core/lcc_regs.svh]
// Constants of the constant-light control: timing, value limits and telegram codes.
// Assumes inclusion by bare name from the core design files only.
`ifndef LCC_REGS_SVH
`define LCC_REGS_SVH

// Clock period and the millisecond unit used for repetition times, in ns.
`define LCC_CLK_NS      5
`define LCC_MS_NS       1000000

// Full scale of a one-byte dimming value and the percentage base.
`define LCC_VAL_MAX     8'hFF
`define LCC_PCT_FULL    17'h00064

// Four-bit relative dimming telegram: direction bit and stop code.
`define LCC_DIM_UP_BIT  1'h1
`define LCC_DIM_STOP    4'h0

// One-bit switching telegram value for lighting on.
`define LCC_SWITCH_ON   1'h1

// Reset values.
`define LCC_SP_RST      16'h0000
`define LCC_VAL_RST     8'h00

`endif

// [testbench/lcc_act_model.sv]
// Actuator model: a dimmer on the far side of the controller's telegram outputs.
// Assumes telegram strobes from the controller on clk, each one cycle long.
`default_nettype none

module lcc_act_model (
	// Clock.
	input  wire logic       clk,
	// Telegrams from the controller.
	input  wire logic       sw_valid,
	input  wire logic       sw_value,
	input  wire logic       dim_valid,
	input  wire logic [3:0] dim_cmd,
	input  wire logic       ch1_strobe,
	input  wire logic [7:0] ch1_value,
	// Observed actuator state.
	output logic [7:0]      level,
	output int              sw_count,
	output int              up_count,
	output int              stop_count,
	output logic [3:0]      last_up
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		level = 8'h00;
		sw_count = 0;
		up_count = 0;
		stop_count = 0;
		last_up = 4'h0;
	end

	// Each up step raises the lamp by a fixed amount; a stop freezes it.
	always @(posedge clk) begin
		if (sw_valid === 1'b1 && sw_value === 1'b1) begin
			sw_count <= sw_count + 1;
			level <= 8'hFF;
		end
		if (dim_valid === 1'b1 && dim_cmd === 4'h0) begin
			stop_count <= stop_count + 1;
		end else if (dim_valid === 1'b1 && dim_cmd[3] === 1'b1) begin
			up_count <= up_count + 1;
			last_up <= dim_cmd;
			level <= (level > 8'hDF) ? 8'hFF : level + 8'h20;
		end
		if (ch1_strobe === 1'b1) begin
			level <= ch1_value;
		end
	end
endmodule : lcc_act_model

`default_nettype wire

// [testbench/lcc_ctrl_tb.sv]
// Self-checking bench of the constant-light controller with a dimmer actuator model.
// Assumes the core package and design files are compiled first.
`default_nettype none

module lcc_ctrl_tb import lcc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] cfg_setpoint, ext_sp_value, measured_lux, repeat_ms, adapt_range;
	logic cfg_overwrite, cfg_download, ext_sp_valid, teach, sp_reset;
	logic startup_start, main_valid;
	logic [1:0] num_channels;
	lcc_ofs_mode_type ofs_mode;
	lcc_su_mode_type su_mode;
	logic [7:0] ofs_hyst, sync_ch2, sync_ch3, fixed_value, main_value;
	logic [8:0] ofs_ch2, ofs_ch3, pct_ch2, pct_ch3;
	logic [2:0] dim_step;
	logic [15:0] setpoint_active;
	logic startup_done, sw_valid, sw_value, dim_valid;
	logic [3:0] dim_cmd, last_up;
	logic [2:0] ch_valid;
	logic [2:0] valid_seen;
	logic [7:0] ch1_value, ch2_value, ch3_value, act_level;
	int sw_count, up_count, stop_count;
	int fail_count = 0;
	int compares = 0;
	int done_count, done_at, s0, u0, t0;

	always #2.5 clk = ~clk;

	lcc_ctrl #(.MS_CYCLES(4)) uut (.clk(clk), .rst_n(rst_n), .cfg_setpoint(cfg_setpoint),
		.cfg_overwrite(cfg_overwrite), .cfg_download(cfg_download),
		.ext_sp_valid(ext_sp_valid), .ext_sp_value(ext_sp_value), .teach(teach),
		.sp_reset(sp_reset), .setpoint_active(setpoint_active), .measured_lux(measured_lux),
		.num_channels(num_channels), .ofs_mode(ofs_mode), .ofs_hyst(ofs_hyst),
		.ofs_ch2(ofs_ch2), .ofs_ch3(ofs_ch3), .pct_ch2(pct_ch2), .pct_ch3(pct_ch3),
		.sync_ch2(sync_ch2), .sync_ch3(sync_ch3), .su_mode(su_mode), .dim_step(dim_step),
		.repeat_ms(repeat_ms), .fixed_value(fixed_value), .adapt_range(adapt_range),
		.startup_start(startup_start), .startup_done(startup_done), .main_valid(main_valid),
		.main_value(main_value), .sw_valid(sw_valid), .sw_value(sw_value),
		.dim_valid(dim_valid), .dim_cmd(dim_cmd), .ch_valid(ch_valid),
		.ch1_value(ch1_value), .ch2_value(ch2_value), .ch3_value(ch3_value));

	lcc_act_model act (.clk(clk), .sw_valid(sw_valid), .sw_value(sw_value),
		.dim_valid(dim_valid), .dim_cmd(dim_cmd), .ch1_strobe(ch_valid[0]),
		.ch1_value(ch1_value), .level(act_level), .sw_count(sw_count),
		.up_count(up_count), .stop_count(stop_count), .last_up(last_up));

	task automatic close_out;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : close_out

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask : step

	// Pulses {external preset, teach, reset, download} for one cycle.
	task automatic sp_pulse(input logic [3:0] s);
		{ext_sp_valid, teach, sp_reset, cfg_download} = s;
		step(1);
		{ext_sp_valid, teach, sp_reset, cfg_download} = 4'h0;
		step(2);
	endtask : sp_pulse

	// The channel strobes stand for one cycle only, so they are caught right after the update.
	task automatic drive_main(input logic [7:0] v);
		main_valid = 1'b1;
		main_value = v;
		step(1);
		main_valid = 1'b0;
		valid_seen = ch_valid;
		step(1);
	endtask : drive_main

	// Starts the startup phase; feed makes the brightness follow the lamp.
	task automatic run_start(input int lim, input bit feed);
		startup_start = 1'b1;
		done_count = 0;
		done_at = -1;
		s0 = sw_count;
		u0 = up_count;
		t0 = stop_count;
		for (int i = 0; i < lim; i++) begin
			step(1);
			startup_start = 1'b0;
			if (feed) begin
				measured_lux = {6'h00, act_level, 2'h0};
			end
			if (startup_done === 1'b1) begin
				done_count++;
				done_at = i;
			end
		end
	endtask : run_start

	task automatic test_setpoint;
		chk(setpoint_active, 16'h0190);
		cfg_overwrite = 1'b0;
		sp_pulse(4'h1);
		chk(setpoint_active, 16'h0190);
		ext_sp_value = 16'h0258;
		sp_pulse(4'h8);
		chk(setpoint_active, 16'h0258);
		sp_pulse(4'h1);
		chk(setpoint_active, 16'h0258);
		cfg_overwrite = 1'b1;
		sp_pulse(4'h1);
		chk(setpoint_active, 16'h0190);
		measured_lux = 16'h0123;
		sp_pulse(4'h4);
		chk(setpoint_active, 16'h0123);
		sp_pulse(4'h1);
		chk(setpoint_active, 16'h0190);
	endtask : test_setpoint

	task automatic test_reldim;
		cfg_setpoint = 16'h012C;
		su_mode = LCC_SU_RELDIM;
		measured_lux = 16'h0000;
		run_start(80, 1'b1);
		chk(16'(up_count - u0), 16'h0003);
		chk({12'h000, last_up}, 16'h000B);
		chk(16'(stop_count - t0), 16'h0001);
		chk(16'(done_count), 16'h0001);
	endtask : test_reldim

	task automatic test_startup;
		cfg_setpoint = 16'h0190;
		measured_lux = 16'h0190;
		su_mode = LCC_SU_SWITCH;
		run_start(6, 1'b0);
		chk(16'(done_at), 16'h0001);
		chk(16'(sw_count - s0), 16'h0000);
		measured_lux = 16'h00C8;
		run_start(6, 1'b0);
		chk(16'(sw_count - s0), 16'h0001);
		chk(16'(done_count), 16'h0001);
		su_mode = LCC_SU_VALUE;
		fixed_value = 8'h40;
		run_start(6, 1'b0);
		chk({8'h00, ch1_value}, 16'h0040);
		num_channels = 2'h2;
		su_mode = LCC_SU_SWITCH;
		fixed_value = 8'h50;
		run_start(6, 1'b0);
		chk(16'(sw_count - s0), 16'h0000);
		chk({8'h00, ch1_value}, 16'h0050);
		su_mode = LCC_SU_RELDIM;
		fixed_value = 8'h60;
		run_start(20, 1'b0);
		chk(16'(up_count - u0), 16'h0000);
		chk({8'h00, ch1_value}, 16'h0060);
		num_channels = 2'h1;
		su_mode = LCC_SU_ADAPT;
		run_start(6, 1'b0);
		chk({8'h00, ch1_value}, 16'h007F);
	endtask : test_startup

	task automatic test_fixed;
		num_channels = 2'h2;
		ofs_mode = LCC_OFS_FIXED;
		drive_main(8'h80);
		chk({13'h0000, valid_seen}, 16'h0003);
		chk({13'h0000, ch_valid}, 16'h0000);
		chk({ch2_value, ch3_value}, 16'h4E8A);
		drive_main(8'h01);
		chk({8'h00, ch3_value}, 16'h000B);
		drive_main(8'h14);
		chk({8'h00, ch2_value}, 16'h0000);
		drive_main(8'h41);
		chk({8'h00, ch2_value}, 16'h0000);
		drive_main(8'h46);
		chk({8'h00, ch2_value}, 16'h0000);
		drive_main(8'h47);
		chk({8'h00, ch2_value}, 16'h0015);
		drive_main(8'h3C);
		chk({8'h00, ch2_value}, 16'h000A);
		drive_main(8'hFA);
		chk({8'h00, ch3_value}, 16'h00FF);
		drive_main(8'h00);
		chk({ch2_value, ch3_value}, 16'h0000);
	endtask : test_fixed

	task automatic test_offsets;
		num_channels = 2'h3;
		ofs_mode = LCC_OFS_INC;
		drive_main(8'h80);
		chk({13'h0000, valid_seen}, 16'h0007);
		chk({ch2_value, ch3_value}, 16'hCC66);
		drive_main(8'h14);
		chk({ch2_value, ch3_value}, 16'h2010);
		drive_main(8'hC8);
		chk({ch2_value, ch3_value}, 16'hFFA0);
		ofs_mode = LCC_OFS_DEC;
		ofs_ch2 = 9'h032;
		drive_main(8'hB4);
		chk({ch2_value, ch3_value}, 16'hB9AF);
		drive_main(8'h3C);
		chk({ch2_value, ch3_value}, 16'h5F19);
		drive_main(8'hFA);
		chk({ch2_value, ch3_value}, 16'hFAFA);
		drive_main(8'h00);
		chk({ch2_value, ch3_value}, 16'h0000);
	endtask : test_offsets

	initial begin
		{cfg_overwrite, cfg_download, ext_sp_valid, teach, sp_reset} = 5'h00;
		{startup_start, main_valid, main_value} = 10'h000;
		cfg_setpoint = 16'h0190;
		ext_sp_value = 16'h0000;
		measured_lux = 16'h0000;
		repeat_ms = 16'h0002;
		adapt_range = 16'h0190;
		num_channels = 2'h1;
		ofs_mode = LCC_OFS_FIXED;
		su_mode = LCC_SU_SWITCH;
		ofs_hyst = 8'h14;
		{sync_ch2, sync_ch3} = 16'hC8C8;
		{ofs_ch2, ofs_ch3} = {9'h1CE, 9'h00A};
		{pct_ch2, pct_ch3} = {9'h0A0, 9'h050};
		fixed_value = 8'h40;
		dim_step = 3'h3;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		step(1);
		test_setpoint();
		test_reldim();
		test_startup();
		test_fixed();
		ofs_ch3 = 9'h1CE;
		test_offsets();
		close_out();
	end

	// Cuts a hang short well beyond the fewer than two hundred cycles the tests need.
	initial begin
		#100000;
		fail_count++;
		close_out();
	end
endmodule : lcc_ctrl_tb

`default_nettype wire
